// *** hw/pimsk_regs.sv ***
/*
 PHY interrupt enable, latched source flags, special control/status and the
 indirectly reached device register spaces, on a plain register port.
 Assumes event inputs synchronous to CLK, single-cycle strobes, never both.
*/
// Contract
// - Each enable bit gates its source; 1 enables, 0 masks; reset 0.
// - Enable bit 9 gates the link-up interrupt.
// - Enable bit 8 gates the wake-on-LAN interrupt.
// - Enable bit 7 gates the line-energy-detected interrupt.
// - Enable bit 6 gates the auto-negotiation-complete interrupt.
// - Enable bit 5 gates the remote fault interrupt.
// - Enable bit 4 gates the link-down interrupt.
// - Enable bit 3 gates the partner acknowledge interrupt.
// - Enable bit 2 gates the parallel-detection fault interrupt.
// - Enable bit 1 gates page received; bits 15:10 and 0 read-only.
// - Enabled events latch source flags; reading the flag register clears them.
// - Status bit 12 shows auto-negotiation complete; resets to 0.
// - Special bits 11:5 reset to 0000010b; software writes that pattern.
// - Speed bits 4:2 report 001, 101 or 110; other codes reserved.
// - Device spaces are reached only through access control and address/data.
// - Only device addresses 3, 7 and 30 are served.
// - Device space words follow the public clause 45 register layout.
// - PCS holds present words 5, 6 and wakeup words 32784 to 32786.
// - PCS holds byte masks 32801 to 32808 and MAC words 32865 to 32867.
// - Auto-negotiation space holds present words 5, 6; other indices absent.
`timescale 1ns/100ps
`include "pimsk_defs.svh"

module pimsk_regs #(
	parameter logic [15:0] AN_PRESENT1 = `PIMSK_PRESENT1_WORD,
	parameter logic [15:0] AN_PRESENT2 = `PIMSK_PRESENT2_WORD,
	parameter logic [15:0] VEND_PRESENT1 = `PIMSK_PRESENT1_WORD,
	parameter logic [15:0] VEND_PRESENT2 = `PIMSK_PRESENT2_WORD,
	// Identification words; values are arbitrary
	parameter logic [15:0] VEND_DEVID1 = 16'h1234,
	parameter logic [15:0] VEND_DEVID2 = 16'h5678
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// Line status levels
	input wire logic LINK_STATUS,
	input wire logic LINE_ENERGY_DETECTED,
	input wire logic AUTONEG_DONE,
	input wire logic [2:0] SPEED_STATE,
	// Event pulses
	input wire logic WAKE_LAN_EVENT,
	input wire logic REMOTE_FAULT_EVENT,
	input wire logic PARTNER_ACK_EVENT,
	input wire logic PARALLEL_DETECT_FAULT_EVENT,
	input wire logic PAGE_RECEIVED_EVENT,
	// Interrupt indication
	output logic PHY_IRQ
);

	localparam int NIRQ = `PIMSK_IRQ_HI - `PIMSK_IRQ_LO + 1;
	localparam int SLOTS = `PIMSK_SLOTS;

	logic [NIRQ-1:0] irq_enable_q;
	logic [NIRQ-1:0] phy_irq_source_flags_q;
	logic [NIRQ-1:0] irq_event;
	logic [6:0] scs_rsv_q;
	logic [2:0] speed_q;
	logic done_q;
	logic link_prev_q;
	logic energy_prev_q;
	logic done_prev_q;
	pimsk_pkg::pimsk_fn_t fn_q;
	logic [4:0] device_space_select_q;
	logic [15:0] index_q;
	logic [15:0] pcs_word_q [SLOTS];
	logic [15:0] rdata_q;
	logic [15:0] mmd_rdata;
	logic [15:0] rd_mux;
	logic [3:0] slot;
	logic slot_hit;
	logic mmd_wr;
	logic mmd_rd;
	logic flags_rd;

	// Strobe decode
	assign flags_rd = RD && (ADDR == `PIMSK_OFS_IRQ_FLAGS);
	assign mmd_wr = WR && (ADDR == `PIMSK_OFS_ADDR_DATA) &&
		(fn_q != pimsk_pkg::PIMSK_FN_ADDR);
	assign mmd_rd = RD && (ADDR == `PIMSK_OFS_ADDR_DATA) &&
		(fn_q != pimsk_pkg::PIMSK_FN_ADDR);

	// Event detection: level edges and pulses
	always_comb begin
		irq_event = '0;
		irq_event[`PIMSK_BIT_LINK_UP - 1] = LINK_STATUS && !link_prev_q;
		irq_event[`PIMSK_BIT_WAKE_LAN - 1] = WAKE_LAN_EVENT;
		irq_event[`PIMSK_BIT_ENERGY - 1] = LINE_ENERGY_DETECTED && !energy_prev_q;
		irq_event[`PIMSK_BIT_AN_DONE - 1] = AUTONEG_DONE && !done_prev_q;
		irq_event[`PIMSK_BIT_REMOTE_FAULT - 1] = REMOTE_FAULT_EVENT;
		irq_event[`PIMSK_BIT_LINK_DOWN - 1] = !LINK_STATUS && link_prev_q;
		irq_event[`PIMSK_BIT_PARTNER_ACK - 1] = PARTNER_ACK_EVENT;
		irq_event[`PIMSK_BIT_PAR_FAULT - 1] = PARALLEL_DETECT_FAULT_EVENT;
		irq_event[`PIMSK_BIT_PAGE_RX - 1] = PAGE_RECEIVED_EVENT;
	end

	// Previous levels for edge detection
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_prev_q <= 1'b0;
			energy_prev_q <= 1'b0;
			done_prev_q <= 1'b0;
		end else begin
			link_prev_q <= LINK_STATUS;
			energy_prev_q <= LINE_ENERGY_DETECTED;
			done_prev_q <= AUTONEG_DONE;
		end
	end

	// Interrupt enable register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_enable_q <= `PIMSK_IRQ_RESET;
		end else if (WR && ADDR == `PIMSK_OFS_IRQ_ENABLE) begin
			irq_enable_q <= WDATA[`PIMSK_IRQ_HI:`PIMSK_IRQ_LO];
		end
	end

	// Latched source flags, one per source; a new event beats the read clear
	for (genvar g = 0; g < NIRQ; g++) begin : g_flag
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				phy_irq_source_flags_q[g] <= 1'b0;
			end else if (irq_event[g] && irq_enable_q[g]) begin
				phy_irq_source_flags_q[g] <= 1'b1;
			end else if (flags_rd) begin
				phy_irq_source_flags_q[g] <= 1'b0;
			end
		end
	end

	// Interrupt indication
	assign PHY_IRQ = |(phy_irq_source_flags_q & irq_enable_q);

	// Special control/status
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			scs_rsv_q <= `PIMSK_SCS_RSV_RESET;
		end else if (WR && ADDR == `PIMSK_OFS_SPECIAL) begin
			scs_rsv_q <= WDATA[`PIMSK_SCS_RSV_HI:`PIMSK_SCS_RSV_LO];
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			done_q <= 1'b0;
		end else begin
			done_q <= AUTONEG_DONE;
		end
	end

	// Speed keeps its last legal code; reserved inputs are not reported
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			speed_q <= `PIMSK_SPD_RESET;
		end else if (SPEED_STATE == `PIMSK_SPD_10_HALF ||
				SPEED_STATE == `PIMSK_SPD_10_FULL ||
				SPEED_STATE == `PIMSK_SPD_100_FULL) begin
			speed_q <= SPEED_STATE;
		end
	end

	// Indirect access control: function and device address
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fn_q <= pimsk_pkg::PIMSK_FN_ADDR;
			device_space_select_q <= '0;
		end else if (WR && ADDR == `PIMSK_OFS_ACCESS_CTRL) begin
			fn_q <= pimsk_pkg::pimsk_fn_t'(WDATA[`PIMSK_ACC_FN_HI:`PIMSK_ACC_FN_LO]);
			device_space_select_q <= WDATA[`PIMSK_ACC_DEV_HI:`PIMSK_ACC_DEV_LO];
		end
	end

	// Register index: loaded in address mode, stepped in the increment modes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			index_q <= '0;
		end else if (WR && ADDR == `PIMSK_OFS_ADDR_DATA &&
				fn_q == pimsk_pkg::PIMSK_FN_ADDR) begin
			index_q <= WDATA;
		end else if ((fn_q == pimsk_pkg::PIMSK_FN_DATA_INC && (mmd_wr || mmd_rd)) ||
				(fn_q == pimsk_pkg::PIMSK_FN_DATA_WINC && mmd_wr)) begin
			index_q <= index_q + 16'h0001;
		end
	end

	// Slot of the writable PCS words
	always_comb begin
		slot = '0;
		slot_hit = 1'b0;
		if (device_space_select_q == `PIMSK_DEV_PCS) begin
			if (index_q >= `PIMSK_IDX_WAKE_CS && index_q <= `PIMSK_IDX_WAKE_CFGB) begin
				slot = 4'(index_q - `PIMSK_IDX_WAKE_CS);
				slot_hit = 1'b1;
			end else if (index_q >= `PIMSK_IDX_MASK_FIRST &&
					index_q <= `PIMSK_IDX_MASK_LAST) begin
				slot = 4'(index_q - `PIMSK_IDX_MASK_FIRST + `PIMSK_SLOT_MASK);
				slot_hit = 1'b1;
			end else if (index_q >= `PIMSK_IDX_MAC_FIRST &&
					index_q <= `PIMSK_IDX_MAC_LAST) begin
				slot = 4'(index_q - `PIMSK_IDX_MAC_FIRST + `PIMSK_SLOT_MAC);
				slot_hit = 1'b1;
			end
		end
	end

	// Writable PCS storage, one word per slot
	for (genvar s = 0; s < SLOTS; s++) begin : g_word
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				pcs_word_q[s] <= '0;
			end else if (mmd_wr && slot_hit && slot == 4'(s)) begin
				pcs_word_q[s] <= WDATA;
			end
		end
	end

	// Device space read; absent devices and indices read zero
	always_comb begin
		mmd_rdata = '0;
		unique case (device_space_select_q)
			`PIMSK_DEV_PCS: begin
				if (slot_hit) begin
					mmd_rdata = pcs_word_q[slot];
				end else if (index_q == `PIMSK_IDX_PRESENT1) begin
					mmd_rdata = `PIMSK_PRESENT1_WORD;
				end else if (index_q == `PIMSK_IDX_PRESENT2) begin
					mmd_rdata = `PIMSK_PRESENT2_WORD;
				end
			end
			`PIMSK_DEV_AN: begin
				if (index_q == `PIMSK_IDX_PRESENT1) begin
					mmd_rdata = AN_PRESENT1;
				end else if (index_q == `PIMSK_IDX_PRESENT2) begin
					mmd_rdata = AN_PRESENT2;
				end
			end
			`PIMSK_DEV_VEND: begin
				if (index_q == `PIMSK_IDX_DEVID1) begin
					mmd_rdata = VEND_DEVID1;
				end else if (index_q == `PIMSK_IDX_DEVID2) begin
					mmd_rdata = VEND_DEVID2;
				end else if (index_q == `PIMSK_IDX_PRESENT1) begin
					mmd_rdata = VEND_PRESENT1;
				end else if (index_q == `PIMSK_IDX_PRESENT2) begin
					mmd_rdata = VEND_PRESENT2;
				end
			end
			default: begin
				mmd_rdata = '0;
			end
		endcase
	end

	// Register read multiplexer
	always_comb begin
		rd_mux = '0;
		unique case (ADDR)
			`PIMSK_OFS_ACCESS_CTRL: begin
				rd_mux[`PIMSK_ACC_FN_HI:`PIMSK_ACC_FN_LO] = fn_q;
				rd_mux[`PIMSK_ACC_DEV_HI:`PIMSK_ACC_DEV_LO] = device_space_select_q;
			end
			`PIMSK_OFS_ADDR_DATA: begin
				rd_mux = (fn_q == pimsk_pkg::PIMSK_FN_ADDR) ? index_q : mmd_rdata;
			end
			`PIMSK_OFS_IRQ_FLAGS: begin
				rd_mux[`PIMSK_IRQ_HI:`PIMSK_IRQ_LO] = phy_irq_source_flags_q;
			end
			`PIMSK_OFS_IRQ_ENABLE: begin
				rd_mux[`PIMSK_IRQ_HI:`PIMSK_IRQ_LO] = irq_enable_q;
			end
			`PIMSK_OFS_SPECIAL: begin
				rd_mux[`PIMSK_SCS_DONE_BIT] = done_q;
				rd_mux[`PIMSK_SCS_RSV_HI:`PIMSK_SCS_RSV_LO] = scs_rsv_q;
				rd_mux[`PIMSK_SCS_SPD_HI:`PIMSK_SCS_SPD_LO] = speed_q;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q <= '0;
		end else if (RD) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= '0;
		end
	end

	assign RDATA = rdata_q;

endmodule

// *** hw/pimsk_defs.svh ***
/*
 Offsets, field positions, reset values and fixed words of the PHY interrupt,
 special status and indirect device register block.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef PIMSK_DEFS_SVH
`define PIMSK_DEFS_SVH

// Directly reached register offsets
`define PIMSK_OFS_ACCESS_CTRL 5'h0d
`define PIMSK_OFS_ADDR_DATA 5'h0e
`define PIMSK_OFS_IRQ_FLAGS 5'h1d
`define PIMSK_OFS_IRQ_ENABLE 5'h1e
`define PIMSK_OFS_SPECIAL 5'h1f

// Interrupt source bit positions
`define PIMSK_BIT_PAGE_RX 1
`define PIMSK_BIT_PAR_FAULT 2
`define PIMSK_BIT_PARTNER_ACK 3
`define PIMSK_BIT_LINK_DOWN 4
`define PIMSK_BIT_REMOTE_FAULT 5
`define PIMSK_BIT_AN_DONE 6
`define PIMSK_BIT_ENERGY 7
`define PIMSK_BIT_WAKE_LAN 8
`define PIMSK_BIT_LINK_UP 9
`define PIMSK_IRQ_LO 1
`define PIMSK_IRQ_HI 9
`define PIMSK_IRQ_RESET 9'h000

// Special control/status fields
`define PIMSK_SCS_DONE_BIT 12
`define PIMSK_SCS_RSV_HI 11
`define PIMSK_SCS_RSV_LO 5
`define PIMSK_SCS_RSV_RESET 7'h02
`define PIMSK_SCS_SPD_HI 4
`define PIMSK_SCS_SPD_LO 2
`define PIMSK_SPD_10_HALF 3'h1
`define PIMSK_SPD_10_FULL 3'h5
`define PIMSK_SPD_100_FULL 3'h6
`define PIMSK_SPD_RESET 3'h1

// Access control fields
`define PIMSK_ACC_FN_HI 15
`define PIMSK_ACC_FN_LO 14
`define PIMSK_ACC_DEV_HI 4
`define PIMSK_ACC_DEV_LO 0

// Device addresses
`define PIMSK_DEV_PCS 5'h03
`define PIMSK_DEV_AN 5'h07
`define PIMSK_DEV_VEND 5'h1e

// Device space indices
`define PIMSK_IDX_DEVID1 16'h0002
`define PIMSK_IDX_DEVID2 16'h0003
`define PIMSK_IDX_PRESENT1 16'h0005
`define PIMSK_IDX_PRESENT2 16'h0006
`define PIMSK_IDX_WAKE_CS 16'h8010
`define PIMSK_IDX_WAKE_CFGB 16'h8012
`define PIMSK_IDX_MASK_FIRST 16'h8021
`define PIMSK_IDX_MASK_LAST 16'h8028
`define PIMSK_IDX_MAC_FIRST 16'h8061
`define PIMSK_IDX_MAC_LAST 16'h8063

// Storage slots of the writable PCS words
`define PIMSK_SLOT_MASK 3
`define PIMSK_SLOT_MAC 11
`define PIMSK_SLOTS 14

// Fixed devices-present words
`define PIMSK_PRESENT1_WORD 16'h0088
`define PIMSK_PRESENT2_WORD 16'h4000

`endif

// *** hw/pimsk_pkg.sv ***
/*
 Types of the PHY interrupt and indirect register block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pimsk_pkg;

	// Indirect access function codes
	typedef enum logic [1:0] {
		PIMSK_FN_ADDR = 2'h0,
		PIMSK_FN_DATA = 2'h1,
		PIMSK_FN_DATA_INC = 2'h2,
		PIMSK_FN_DATA_WINC = 2'h3
	} pimsk_fn_t;

endpackage

// *** sim/pimsk_regs_sva.sv ***
/*
 Port checker for the PHY interrupt and indirect register block.
 Assumes binding to pimsk_regs and the block's header on the include path.
*/
`timescale 1ns/100ps
`include "pimsk_defs.svh"

module pimsk_regs_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// Status, event and interrupt
	input wire logic AUTONEG_DONE,
	input wire logic WAKE_LAN_EVENT,
	input wire logic PHY_IRQ
);
	logic [9:1] en_q;
	logic rd_fl;
	logic rd_sp;
	default clocking dc @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Enable shadow
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			en_q <= 9'h000;
		end else if (WR && ADDR == `PIMSK_OFS_IRQ_ENABLE) begin
			en_q <= WDATA[9:1];
		end
	end
	assign rd_fl = RD && ADDR == `PIMSK_OFS_IRQ_FLAGS;
	assign rd_sp = RD && ADDR == `PIMSK_OFS_SPECIAL;
	a_idle_rdata_zero: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_enable_readback: assert property (RD && ADDR == 5'h1e |=> RDATA == {6'h00, $past(en_q), 1'b0})
		else $error("enable readback wrong");
	a_irq_needs_enable: assert property (PHY_IRQ |-> en_q != 9'h000)
		else $error("interrupt with all sources masked");
	a_wake_sets_irq: assert property (WAKE_LAN_EVENT && en_q[8] && !WR |=> PHY_IRQ)
		else $error("enabled wake event gave no interrupt");
	a_irq_holds: assert property (PHY_IRQ && !WR && !rd_fl |=> PHY_IRQ)
		else $error("interrupt dropped without read or mask");
	a_flag_fixed_bits: assert property (rd_fl |=> RDATA[15:10] == 6'h00 && !RDATA[0])
		else $error("flag reserved bits set");
	a_done_bit_lag: assert property (rd_sp |=> RDATA[12] == $past(AUTONEG_DONE, 2))
		else $error("done bit wrong");
	a_special_fixed: assert property (rd_sp |=> RDATA[15:13] == 3'h0 && RDATA[1:0] == 2'h0)
		else $error("special reserved bits set");
	a_speed_legal: assert property (rd_sp |=> RDATA[4:2] inside {3'h1, 3'h5, 3'h6})
		else $error("reserved speed code read");
	a_unmapped_zero: assert property (RD && !(ADDR inside {5'h0d, 5'h0e, 5'h1d, 5'h1e, 5'h1f})
		|=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	c_flag_read: cover property (rd_fl ##1 RDATA != 16'h0000);
	c_irq_masked: cover property (PHY_IRQ && WR ##1 !PHY_IRQ);
	c_done_seen: cover property (rd_sp ##1 RDATA[12]);
endmodule

bind pimsk_regs pimsk_regs_chk i_pimsk_regs_chk (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .AUTONEG_DONE(AUTONEG_DONE),
	.WAKE_LAN_EVENT(WAKE_LAN_EVENT), .PHY_IRQ(PHY_IRQ));

// *** sim/testbench.sv ***
/*
 Self-checking bench for the PHY interrupt and indirect register block.
 Assumes the block, its header and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`include "pimsk_defs.svh"

module testbench;
	localparam logic [15:0] DEVID1 = 16'h0c3c; // Arbitrary value
	logic clk, reset_n, wr, rd, link, energy, an_done, irq;
	logic [4:0] addr;
	logic [4:0] pulse;
	logic [2:0] speed;
	logic [15:0] wdata, rdata;
	int fails = 0;
	int samples_checked = 0;

	pimsk_regs #(.VEND_DEVID1(DEVID1)) i_pimsk_regs (.CLK(clk), .RESET_N(reset_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.LINK_STATUS(link), .LINE_ENERGY_DETECTED(energy), .AUTONEG_DONE(an_done),
		.SPEED_STATE(speed), .WAKE_LAN_EVENT(pulse[4]), .REMOTE_FAULT_EVENT(pulse[3]),
		.PARTNER_ACK_EVENT(pulse[2]), .PARALLEL_DETECT_FAULT_EVENT(pulse[1]),
		.PAGE_RECEIVED_EVENT(pulse[0]), .PHY_IRQ(irq));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(what, e, rdata);
	endtask
	task automatic sel(input logic [4:0] dev, input logic [15:0] idx);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, {11'h000, dev});
		wr_reg(`PIMSK_OFS_ADDR_DATA, idx);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, {pimsk_pkg::PIMSK_FN_DATA, 9'h000, dev});
	endtask
	// Pre level, then the edge or pulse of source b
	task automatic fire(input int b);
		@(posedge clk);
		link <= (b == 4);
		energy <= 1'b0;
		an_done <= 1'b0;
		@(posedge clk);
		link <= (b == 9);
		energy <= (b == 7);
		an_done <= (b == 6);
		pulse <= {b == 8, b == 5, b == 3, b == 2, b == 1};
		@(posedge clk);
		pulse <= 5'h00;
		#1;
	endtask

	task automatic test_reset;
		rd_chk("enable", `PIMSK_OFS_IRQ_ENABLE, 16'h0000);
		rd_chk("flags", `PIMSK_OFS_IRQ_FLAGS, 16'h0000);
		rd_chk("special", `PIMSK_OFS_SPECIAL, 16'h0044);
		wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'hffff);
		rd_chk("enable all", `PIMSK_OFS_IRQ_ENABLE, 16'h03fe);
		wr_reg(`PIMSK_OFS_IRQ_FLAGS, 16'hffff);
		rd_chk("flags ro", `PIMSK_OFS_IRQ_FLAGS, 16'h0000);
		rd_chk("unmapped", 5'h10, 16'h0000);
		$display("test_reset done");
	endtask
	task automatic test_sources;
		for (int b = `PIMSK_IRQ_LO; b <= `PIMSK_IRQ_HI; b++) begin
			wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'h0000);
			fire(b);
			chk("masked irq", 16'h0000, {15'h0000, irq});
			rd_chk("masked flags", `PIMSK_OFS_IRQ_FLAGS, 16'h0000);
			wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'h0001 << b);
			fire(b);
			chk("irq", 16'h0001, {15'h0000, irq});
			rd_chk("flags", `PIMSK_OFS_IRQ_FLAGS, 16'h0001 << b);
			chk("irq cleared", 16'h0000, {15'h0000, irq});
		end
		wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'h0020);
		fire(5);
		wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'h0000);
		#1 chk("irq masked late", 16'h0000, {15'h0000, irq});
		wr_reg(`PIMSK_OFS_IRQ_ENABLE, 16'h0020);
		#1 chk("irq unmasked", 16'h0001, {15'h0000, irq});
		rd_chk("kept flag", `PIMSK_OFS_IRQ_FLAGS, 16'h0020);
		$display("test_sources done");
	endtask
	task automatic test_special;
		logic [2:0] sp[4] = '{3'h5, 3'h6, 3'h7, 3'h1};
		logic [2:0] ex[4] = '{3'h5, 3'h6, 3'h6, 3'h1};
		wr_reg(`PIMSK_OFS_SPECIAL, 16'h0040);
		an_done <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			speed <= sp[i];
			repeat (2) @(posedge clk);
			rd_chk("special", `PIMSK_OFS_SPECIAL, {4'h1, 7'h02, ex[i], 2'h0});
		end
		an_done <= 1'b0;
		repeat (2) @(posedge clk);
		rd_chk("not done", `PIMSK_OFS_SPECIAL, 16'h0044);
		$display("test_special done");
	endtask
	task automatic test_indirect;
		logic [4:0] dv[6] = '{5'h03, 5'h03, 5'h07, 5'h07, 5'h1e, 5'h04};
		logic [15:0] ro[6] = '{16'h0005, 16'h0006, 16'h0005, 16'h0006, 16'h0002, 16'h0005};
		logic [15:0] rv[6] = '{16'h0088, 16'h4000, 16'h0088, 16'h4000, DEVID1, 16'h0000};
		logic [15:0] ix[9] = '{16'h8010, 16'h8011, 16'h8012, 16'h8021, 16'h8028, 16'h8061,
			16'h8063, 16'h8029, 16'h0007};
		for (int i = 0; i < 6; i++) begin
			sel(dv[i], ro[i]);
			wr_reg(`PIMSK_OFS_ADDR_DATA, 16'hffff);
			rd_chk("fixed word", `PIMSK_OFS_ADDR_DATA, rv[i]);
		end
		for (int i = 0; i < 9; i++) begin
			sel(`PIMSK_DEV_PCS, ix[i]);
			wr_reg(`PIMSK_OFS_ADDR_DATA, ix[i] ^ 16'h3c3c);
		end
		for (int i = 0; i < 9; i++) begin
			sel(`PIMSK_DEV_PCS, ix[i]);
			rd_chk("pcs word", `PIMSK_OFS_ADDR_DATA, i < 7 ? ix[i] ^ 16'h3c3c : 16'h0000);
		end
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, 16'h0003);
		wr_reg(`PIMSK_OFS_ADDR_DATA, 16'h8061);
		rd_chk("index", `PIMSK_OFS_ADDR_DATA, 16'h8061);
		// Stepping modes: every access steps, then writes only
		sel(`PIMSK_DEV_PCS, 16'h8021);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, 16'h8003);
		wr_reg(`PIMSK_OFS_ADDR_DATA, 16'ha001);
		wr_reg(`PIMSK_OFS_ADDR_DATA, 16'ha002);
		rd_chk("step word", `PIMSK_OFS_ADDR_DATA, 16'h0000);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, 16'h0003);
		rd_chk("step index", `PIMSK_OFS_ADDR_DATA, 16'h8024);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, 16'hc003);
		rd_chk("wstep read", `PIMSK_OFS_ADDR_DATA, 16'h0000);
		wr_reg(`PIMSK_OFS_ADDR_DATA, 16'ha005);
		wr_reg(`PIMSK_OFS_ACCESS_CTRL, 16'h0003);
		rd_chk("wstep index", `PIMSK_OFS_ADDR_DATA, 16'h8025);
		sel(`PIMSK_DEV_PCS, 16'h8022);
		rd_chk("stepped word", `PIMSK_OFS_ADDR_DATA, 16'ha002);
		sel(`PIMSK_DEV_PCS, 16'h8024);
		rd_chk("wstepped word", `PIMSK_OFS_ADDR_DATA, 16'ha005);
		$display("test_indirect done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end
	initial begin
		{reset_n, wr, rd, link, energy, an_done, pulse, speed} = '0;
		addr = 5'h00;
		wdata = 16'h0000;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		test_reset();
		test_sources();
		test_special();
		test_indirect();
		finish_test();
	end
endmodule
